// ---- hbr_ccd_model.sv ----
`timescale 1ns/1ps
// ****************************************
// sensor shift register: counts clocks received
// ****************************************
module hbr_ccd_model (
    input wire logic mclk,
    input wire logic h1,
    input wire logic h2,
    output int       n1,
    output int       n2
);
    logic h1_d = 1'b0;
    logic h2_d = 1'b0;
    initial begin
        n1 = 0;
        n2 = 0;
    end
    always @(posedge mclk) begin
        h1_d <= h1;
        h2_d <= h2;
        if (h1 === 1'b1 && h1_d !== 1'b1) n1 <= n1 + 1;
        if (h2 === 1'b1 && h2_d !== 1'b1) n2 <= n2 + 1;
    end
endmodule

// ---- hbr_checker.sv ----
`timescale 1ns/1ps
module hbr_checker (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        odd_line,
    input wire logic        horizontal_blanking,
    input wire logic        horiz_clock_phase_one,
    input wire logic        horiz_clock_phase_two,
    input wire logic        even_line_toggle_hit
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ****************************************
    // register port
    // ****************************************
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside read slot");
    AST_RD_HIGH: assert property ($past(rd) |-> rdata[31:13] == 19'h0)
        else $error("read data upper bits set");
    // ****************************************
    // pattern outputs
    // ****************************************
    AST_TOG_EVEN: assert property (even_line_toggle_hit |-> !$past(odd_line))
        else $error("toggle hit on odd line");
    AST_TOG_ONE: assert property (even_line_toggle_hit |-> !horiz_clock_phase_one && !horiz_clock_phase_two)
        else $error("toggle hit beside repeat pulse");
    AST_H1_BLANK: assert property (horiz_clock_phase_one |-> $past(horizontal_blanking))
        else $error("phase one pulse outside blanking");
    AST_H2_BLANK: assert property (horiz_clock_phase_two |-> $past(horizontal_blanking))
        else $error("phase two pulse outside blanking");
    AST_H1_PULSE: assert property ($rose(horiz_clock_phase_one) |=> !horiz_clock_phase_one)
        else $error("phase one pulse too wide");
    AST_H2_PULSE: assert property ($rose(horiz_clock_phase_two) |=> !horiz_clock_phase_two)
        else $error("phase two pulse too wide");
    cover property ($rose(horiz_clock_phase_one) && odd_line);
    cover property ($rose(horiz_clock_phase_two));
    cover property (even_line_toggle_hit);
endmodule

bind hbr_hblank_repeat hbr_checker hbr_checker_inst (.mclk(mclk), .rst(rst), .rd(rd), .rdata(rdata),
    .odd_line(odd_line), .horizontal_blanking(horizontal_blanking), .horiz_clock_phase_one(horiz_clock_phase_one),
    .horiz_clock_phase_two(horiz_clock_phase_two), .even_line_toggle_hit(even_line_toggle_hit));

// ---- hbr_defs.svh ----
`ifndef HBR_DEFS_SVH
`define HBR_DEFS_SVH

// ****************************************
// register addresses (word index)
// ****************************************
`define HBR_A_MODE      6'h00
`define HBR_A_AREA_LEN  6'h01
`define HBR_A_TOG_BASE  6'h02
`define HBR_A_P1_BASE   6'h08
`define HBR_A_P2_BASE   6'h10
`define HBR_A_START_BASE 6'h18
`define HBR_A_OSEL_BASE 6'h1C
`define HBR_A_STATUS    6'h24

// ****************************************
// fields, modes and reset values
// ****************************************
`define HBR_CNT_W       4
`define HBR_MODE_NORMAL 2'h0
`define HBR_MODE_MIX    2'h1
`define HBR_MODE_ADV    2'h2
`define HBR_LAST_AREA   3'h5
`define HBR_POS_MAX     13'h1FFF
`define HBR_AREA_LEN_RST 13'h0040

`endif

// ---- hbr_hblank_repeat.sv ----
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "hbr_defs.svh"

module hbr_hblank_repeat
    import hbr_pkg::*;
#(
    parameter int N_AREAS = 6,
    parameter int POS_W   = 13
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [5:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    input  wire logic [12:0] pix_cnt,
    input  wire logic        odd_line,
    input  wire logic        horizontal_blanking,
    output logic             horiz_clock_phase_one,
    output logic             horiz_clock_phase_two,
    output logic             even_line_toggle_hit
);

    // ****************************************
    // elaboration checks
    // ****************************************
    if (N_AREAS != 6 || POS_W != 13) begin : g_chk
        $error("hbr_hblank_repeat: only 6 areas of 13-bit positions supported");
    end

    hbr_state_t s_r;
    hbr_state_t s_nxt;

    logic [2:0]  sel;
    logic        sel_ok;
    logic [11:0] c1;
    logic [11:0] c2;
    logic        hb_rise;

    always_comb begin
        s_nxt = s_r;

        // ****************************************
        // register writes
        // ****************************************
        if (wr) begin
            if (addr == `HBR_A_MODE) begin
                s_nxt.mode = wdata[1:0];
            end
            if (addr == `HBR_A_AREA_LEN) begin
                s_nxt.area_len = wdata[12:0];
            end
            for (int i = 0; i < 5; i++) begin
                if (addr == `HBR_A_TOG_BASE + 6'(i)) begin
                    s_nxt.tog[i] = wdata[12:0];
                end
            end
            for (int i = 0; i < 6; i++) begin
                if (addr == `HBR_A_P1_BASE + 6'(i)) begin
                    s_nxt.p1[i] = wdata[11:0];
                end
                if (addr == `HBR_A_P2_BASE + 6'(i)) begin
                    s_nxt.p2[i] = wdata[11:0];
                end
                if (addr == `HBR_A_OSEL_BASE + 6'(i)) begin
                    s_nxt.osel[i] = wdata[2:0];
                end
            end
            for (int i = 0; i < 3; i++) begin
                if (addr == `HBR_A_START_BASE + 6'(i)) begin
                    s_nxt.start[i] = wdata[12:0];
                end
            end
        end

        // ****************************************
        // register reads, data valid one cycle later only
        // ****************************************
        s_nxt.rdata = '0;
        if (rd) begin
            if (addr == `HBR_A_MODE) begin
                s_nxt.rdata = {30'h0, s_r.mode};
            end
            if (addr == `HBR_A_AREA_LEN) begin
                s_nxt.rdata = {19'h0, s_r.area_len};
            end
            if (addr == `HBR_A_STATUS) begin
                s_nxt.rdata = {24'h0, 2'h0, s_r.st == HBR_PLAY, s_r.st == HBR_DONE, 1'b0, s_r.area};
            end
            for (int i = 0; i < 5; i++) begin
                if (addr == `HBR_A_TOG_BASE + 6'(i)) begin
                    s_nxt.rdata = {19'h0, s_r.tog[i]};
                end
            end
            for (int i = 0; i < 6; i++) begin
                if (addr == `HBR_A_P1_BASE + 6'(i)) begin
                    s_nxt.rdata = {20'h0, s_r.p1[i]};
                end
                if (addr == `HBR_A_P2_BASE + 6'(i)) begin
                    s_nxt.rdata = {20'h0, s_r.p2[i]};
                end
                if (addr == `HBR_A_OSEL_BASE + 6'(i)) begin
                    s_nxt.rdata = {29'h0, s_r.osel[i]};
                end
            end
            for (int i = 0; i < 3; i++) begin
                if (addr == `HBR_A_START_BASE + 6'(i)) begin
                    s_nxt.rdata = {19'h0, s_r.start[i]};
                end
            end
        end

        // ****************************************
        // even-line toggle match, modes 0 and 1
        // ****************************************
        s_nxt.tog_hit = 1'b0;
        if ((s_r.mode == `HBR_MODE_NORMAL || s_r.mode == `HBR_MODE_MIX) && !odd_line) begin
            for (int i = 0; i < 5; i++) begin
                if (pix_cnt == s_r.tog[i]) begin
                    s_nxt.tog_hit = 1'b1;
                end
            end
        end

        // ****************************************
        // advanced mode area player
        // ****************************************
        s_nxt.hb_d = horizontal_blanking;
        hb_rise    = horizontal_blanking && !s_r.hb_d;
        // odd lines reorder all areas through osel; out-of-range selector plays nothing
        sel    = odd_line ? s_r.osel[s_r.area] : s_r.area;
        sel_ok = (sel <= `HBR_LAST_AREA);
        c1     = sel_ok ? s_r.p1[sel] : 12'h000;
        c2     = sel_ok ? s_r.p2[sel] : 12'h000;

        // pulse engines: high while ph is 0, one count used per high/low pair
        if (s_r.rem1 != 4'h0) begin
            s_nxt.ph1 = !s_r.ph1;
            if (s_r.ph1) begin
                s_nxt.rem1 = s_r.rem1 - 4'h1;
            end
        end
        if (s_r.rem2 != 4'h0) begin
            s_nxt.ph2 = !s_r.ph2;
            if (s_r.ph2) begin
                s_nxt.rem2 = s_r.rem2 - 4'h1;
            end
        end

        case (s_r.st)
            HBR_IDLE: begin
                if (hb_rise && s_r.mode == `HBR_MODE_ADV) begin
                    s_nxt.st   = HBR_PLAY;
                    s_nxt.area = 3'h0;
                    s_nxt.lpix = 13'h0000;
                end
            end
            HBR_PLAY: begin
                for (int k = 0; k < 3; k++) begin
                    if (s_r.lpix == s_r.start[k]) begin
                        // a zero count loads nothing and so suppresses the group
                        s_nxt.rem1 = c1[k*`HBR_CNT_W +: `HBR_CNT_W];
                        s_nxt.ph1  = 1'b0;
                        s_nxt.rem2 = c2[k*`HBR_CNT_W +: `HBR_CNT_W];
                        s_nxt.ph2  = 1'b0;
                    end
                end
                s_nxt.lpix = s_r.lpix + 13'h0001;
                if (s_r.lpix == s_r.area_len) begin
                    s_nxt.lpix = 13'h0000;
                    if (s_r.area == `HBR_LAST_AREA) begin
                        s_nxt.st = HBR_DONE;
                    end else begin
                        s_nxt.area = s_r.area + 3'h1;
                    end
                end
            end
            HBR_DONE: begin
                s_nxt.st = HBR_DONE;
            end
            default: begin
                s_nxt.st = HBR_IDLE;
            end
        endcase

        // leaving blanking or mode 2 ends everything at once
        if (!horizontal_blanking || s_r.mode != `HBR_MODE_ADV) begin
            s_nxt.st   = HBR_IDLE;
            s_nxt.rem1 = 4'h0;
            s_nxt.rem2 = 4'h0;
            s_nxt.ph1  = 1'b0;
            s_nxt.ph2  = 1'b0;
        end

        s_nxt.h1 = (s_nxt.rem1 != 4'h0) && !s_nxt.ph1;
        s_nxt.h2 = (s_nxt.rem2 != 4'h0) && !s_nxt.ph2;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r          <= '0;
            s_r.st       <= HBR_IDLE;
            s_r.area_len <= `HBR_AREA_LEN_RST;
            for (int k = 0; k < 3; k++) begin
                s_r.start[k] <= `HBR_POS_MAX;
            end
            for (int i = 0; i < 6; i++) begin
                s_r.osel[i] <= 3'(i);
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata                 = s_r.rdata;
    assign horiz_clock_phase_one = s_r.h1;
    assign horiz_clock_phase_two = s_r.h2;
    assign even_line_toggle_hit  = s_r.tog_hit;

endmodule

// ---- hbr_pkg.sv ----
package hbr_pkg;
    typedef enum logic [2:0] {
        HBR_IDLE = 3'b001,
        HBR_PLAY = 3'b010,
        HBR_DONE = 3'b100
    } hbr_st_t;

    typedef struct packed {
        logic [1:0]        mode;
        logic [12:0]       area_len;
        logic [4:0][12:0]  tog;
        logic [5:0][11:0]  p1;
        logic [5:0][11:0]  p2;
        logic [2:0][12:0]  start;
        logic [5:0][2:0]   osel;
        hbr_st_t           st;
        logic [2:0]        area;
        logic [12:0]       lpix;
        logic              hb_d;
        logic [3:0]        rem1;
        logic [3:0]        rem2;
        logic              ph1;
        logic              ph2;
        logic              h1;
        logic              h2;
        logic              tog_hit;
        logic [31:0]       rdata;
    } hbr_state_t;
endpackage

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  addr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_p = 1'b0;
    logic [31:0] rdata;
    // parked where no toggle position can match, so no stray hits before a sweep
    logic [12:0] pix_cnt = 13'h1FFF;
    logic        odd_line = 1'b0;
    logic        hb = 1'b0;
    logic        h1, h2, hit;
    logic [31:0] rq[$];
    logic [11:0] p1[6], p2[6], mk;
    logic [12:0] tv[5];
    logic [2:0]  sel[6];
    logic [31:0] seed = 32'h1A830C35;
    int          failures = 0, cmp_count = 0, hits = 0, n1, n2, e1, e2, b1, b2, a;

    hbr_hblank_repeat hbr_hblank_repeat_inst (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pix_cnt(pix_cnt), .odd_line(odd_line), .horizontal_blanking(hb),
        .horiz_clock_phase_one(h1), .horiz_clock_phase_two(h2), .even_line_toggle_hit(hit));
    hbr_ccd_model hbr_ccd_model_inst (.mclk(mclk), .h1(h1), .h2(h2), .n1(n1), .n2(n2));

    always #4 mclk = ~mclk;
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int sum(input logic [11:0] v);
        return int'(v[3:0]) + int'(v[7:4]) + int'(v[11:8]);
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [5:0] ad, input logic [31:0] d);
        @(posedge mclk);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [5:0] ad, input logic [31:0] exp);
        @(posedge mclk);
        addr <= ad;
        rd <= 1'b1;
        rq.push_back(exp);
        @(posedge mclk);
        rd <= 1'b0;
    endtask
    task automatic blank(input logic odd);
        @(posedge mclk);
        odd_line <= odd;
        hb <= 1'b1;
        repeat (400) @(posedge mclk);
        hb <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ****************************************
    // result watchers
    // ****************************************
    always @(posedge mclk) rd_p <= rd;
    always @(negedge mclk) if (rd_p) cmp(rdata, rq.pop_front());
    always @(negedge mclk) if (hit === 1'b1) hits++;
    initial begin
        #400000;
        failures++;
        complete_run();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd_reg(6'h1C + i[5:0], i);
            rd_reg(6'h08 + i[5:0], 32'h0);
        end
        rd_reg(6'h18, 32'h1FFF);
        rd_reg(6'h3F, 32'h0);
        for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            tv[k] = 13'(10 * k) + {10'h0, seed[2:0]};
            wr_reg(6'h02 + k[5:0], {19'h0, tv[k]});
            rd_reg(6'h02 + k[5:0], {19'h0, tv[k]});
        end
        for (int m = 0; m < 6; m++) begin
            wr_reg(6'h00, m / 2);
            odd_line <= m[0];
            hits = 0;
            for (int p = 0; p < 64; p++) begin
                @(posedge mclk);
                pix_cnt <= p[12:0];
            end
            repeat (3) @(posedge mclk);
            cmp(hits, (m < 4 && !m[0]) ? 5 : 0);
        end
        // starts leave room for fifteen pulses after A
        wr_reg(6'h18, 32'h2);
        wr_reg(6'h19, 32'h22);
        wr_reg(6'h1A, 32'h32);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            p1[i] = seed[11:0] & 12'h77F;
            p2[i] = seed[27:16] & 12'h77F;
            sel[i] = seed[31:29];
            wr_reg(6'h08 + i[5:0], {20'h0, p1[i]});
            wr_reg(6'h10 + i[5:0], {20'h0, p2[i]});
            wr_reg(6'h1C + i[5:0], {29'h0, sel[i]});
            rd_reg(6'h10 + i[5:0], {20'h0, p2[i]});
        end
        p1[0] = 12'h70F;
        wr_reg(6'h08, 32'h70F);
        rd_reg(6'h08, 32'h70F);
        for (int pass = 0; pass < 3; pass++) begin
            if (pass == 2) wr_reg(6'h1A, 32'h1FFF);
            mk = (pass == 2) ? 12'h0FF : 12'hFFF;
            e1 = 0;
            e2 = 0;
            for (int i = 0; i < 6; i++) begin
                a = (pass == 1) ? int'(sel[i]) : i;
                if (a < 6) e1 += sum(p1[a] & mk);
                if (a < 6) e2 += sum(p2[a] & mk);
            end
            b1 = n1;
            b2 = n2;
            blank(pass == 1);
            cmp(n1 - b1, e1);
            cmp(n2 - b2, e2);
        end
        complete_run();
    end
endmodule
